// >>> hdl/cluster_pkg.sv
// constants and carrier types for the logic cluster control block
// assumes an APB master on clk and pins from the routing fabric on foreign timing
package cluster_pkg;

    // ------------------------
    // structure sizes
    // ------------------------
    localparam int NUM_CELLS = 10;
    localparam int NUM_ROW_CLK = 6;
    localparam int NUM_CTRL = 10;
    localparam int NUM_ROUTE = 32;
    localparam int SRC_W = 5;
    localparam int SEL_W = 3;
    localparam int ADDR_W = 12;

    // ------------------------
    // register byte offsets
    // ------------------------
    localparam logic [ADDR_W-1:0] ADDR_CLK_CFG = 12'h000;
    localparam logic [ADDR_W-1:0] ADDR_CTRL_EN = 12'h004;
    localparam logic [ADDR_W-1:0] ADDR_LOCAL = 12'h008;
    localparam logic [ADDR_W-1:0] ADDR_OPERAND = 12'h00c;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h010;
    localparam logic [ADDR_W-1:0] ADDR_CELL_BASE = 12'h020;
    localparam logic [ADDR_W-1:0] ADDR_CELL_END = 12'h048;

    // ------------------------
    // clock config fields
    // ------------------------
    localparam int CLK1_SEL_LSB = 0;
    localparam int CLK1_FALL_BIT = 3;
    localparam int CLK2_SEL_LSB = 4;
    localparam int CLK2_FALL_BIT = 7;
    localparam int DUAL_EDGE_BIT = 8;
    localparam int ACLR1_SEL_LSB = 9;
    localparam int CLK_CFG_W = 12;

    // ------------------------
    // control enable / local control bit positions
    // ------------------------
    localparam int EN_CLK1 = 0;
    localparam int EN_CLK2 = 1;
    localparam int EN_GATE1 = 2;
    localparam int EN_GATE2 = 3;
    localparam int EN_ACLR1 = 4;
    localparam int EN_ACLR2 = 5;
    localparam int EN_SCLR = 6;
    localparam int EN_ALOAD = 7;
    localparam int EN_SLOAD = 8;
    localparam int EN_ADDSUB = 9;
    localparam int LC_GATE1 = 0;
    localparam int LC_GATE2 = 1;
    localparam int LC_ACLR1 = 2;
    localparam int LC_ACLR2 = 3;
    localparam int LC_ALOAD = 4;
    localparam int LC_SCLR = 5;
    localparam int LC_SLOAD = 6;
    localparam int LC_ADDSUB = 7;
    localparam int LC_CLK1 = 8;
    localparam int LC_CLK2 = 9;
    localparam int LOCAL_W = 10;
    localparam int OP_B_LSB = 16;

    // ------------------------
    // status fields
    // ------------------------
    localparam int ST_LUT_LSB = 10;
    localparam int ST_COUNT_LSB = 20;
    localparam int ST_COUT_BIT = 24;
    localparam int ST_DUAL_BIT = 25;

    // ------------------------
    // reset values
    // ------------------------
    localparam logic [CLK_CFG_W-1:0] CLK_CFG_RST = 12'h010;
    localparam logic [NUM_CTRL-1:0] CTRL_EN_RST = 10'h000;
    localparam logic [LOCAL_W-1:0] LOCAL_RST = 10'h000;

    // per-cell configuration word, low bits of the cell register
    typedef struct packed {
        logic [SRC_W-1:0] d4_src;
        logic [SRC_W-1:0] d3_src;
        logic reg_chain_en;
        logic lut_chain_en;
        logic arith;
        logic aclr_sel;
        logic clk_sel;
        logic [15:0] mask;
    } cell_cfg_t;

    localparam int CELL_CFG_W = $bits(cell_cfg_t);
    localparam cell_cfg_t CELL_CFG_RST = '0;

    // cluster-wide controls as the cells see them
    typedef struct packed {
        logic [1:0] clk_evt;
        logic [1:0] aclr;
        logic aload;
        logic sclr;
        logic sload;
        logic addsub;
    } cluster_ctrl_t;

    // operand and chain inputs of one cell
    typedef struct packed {
        logic d1;
        logic d2;
        logic d3;
        logic d4;
        logic lut_chain;
        logic reg_chain;
        logic carry;
    } cell_in_t;

endpackage : cluster_pkg

// >>> hdl/logic_cell.sv
// one logic cell: lookup table, one-bit add/subtract and its register
// assumes controls already gated and synchronous to clk
module logic_cell
    import cluster_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // configuration and cluster controls
    input wire cluster_pkg::cell_cfg_t cfg,
    input wire cluster_pkg::cluster_ctrl_t ctrl,
    input wire cluster_pkg::cell_in_t din,
    // results
    output logic lut_out,
    output logic carry_out,
    output logic q
);
    typedef struct packed {
        logic q;
    } cell_state_t;

    cell_state_t s_q;
    cell_state_t s_d;
    logic d4_eff;
    logic b_eff;
    logic reg_d;
    logic evt;
    logic clr;

    // lookup or arithmetic result
    always_comb
    begin
        d4_eff = cfg.lut_chain_en ? din.lut_chain : din.d4; // RULE9
        b_eff = din.d2 ^ ctrl.addsub; // RULE14
        if (cfg.arith)
        begin
            lut_out = din.d1 ^ b_eff ^ din.carry; // RULE8
            carry_out = (din.d1 & b_eff) | (din.carry & (din.d1 ^ b_eff));
        end
        else
        begin
            lut_out = cfg.mask[{d4_eff, din.d3, din.d2, din.d1}];
            carry_out = 1'b0;
        end
    end

    // register next state: clear beats load beats clocked data
    always_comb
    begin
        reg_d = cfg.reg_chain_en ? din.reg_chain : lut_out; // RULE10
        evt = ctrl.clk_evt[cfg.clk_sel]; // RULE3
        clr = ctrl.aclr[cfg.aclr_sel]; // RULE6
        s_d = s_q;
        if (clr)
            s_d.q = 1'b0; // RULE15
        else if (ctrl.aload)
            s_d.q = din.d3; // RULE7
        else if (evt)
        begin
            if (ctrl.sclr)
                s_d.q = 1'b0; // RULE15
            else if (ctrl.sload)
                s_d.q = din.d3;
            else
                s_d.q = reg_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign q = s_q.q;

endmodule : logic_cell

// >>> hdl/logic_cluster_control.sv
// control and chaining of one logic cluster, registers over APB
// assumes row clocks and routing pins are asynchronous to clk
//
// Summary of operation
// RULE1: the cluster holds exactly ten logic cells sharing controls and routing.
// RULE2: controls are two clocks, two gates, two clears, preset, loads, add/sub.
// RULE3: a cell on cluster clock one uses gate one; likewise for two.
// RULE4: dual-edge clocking of one row line occupies both cluster clocks.
// RULE5: a low clock gate stops its cluster clock entirely.
// RULE6: two independent asynchronous clears and one asynchronous preset/load.
// RULE7: asynchronous load presets the register when its load data is high.
// RULE8: add/subtract select makes each cell a one-bit adder or subtractor.
// RULE9: lookup output chains straight into the next cell's lookup.
// RULE10: register output chains straight into the next cell's register.
// RULE11: local routing takes row/column, own outputs, left and right links.
// RULE12: each cell reaches thirty other cells via local and direct links.
// RULE13: controls are chosen from six row clock lines and local routing.
// RULE14: subtraction inverts operand b and forces carry-in one at cell zero.
// RULE15: synchronous clear/load need a gated edge; asynchronous clear wins always.
module logic_cluster_control
    import cluster_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // row clock lines and routing fabric pins
    input wire logic [5:0] row_clk,
    input wire logic [1:0] row_col_in,
    input wire logic [9:0] link_left_in,
    input wire logic [9:0] link_right_in,
    input wire logic carry_in,
    input wire logic reg_chain_in,
    // outputs toward neighbours
    output logic [9:0] link_out,
    output logic carry_out,
    output logic reg_chain_out
);
    import cluster_pkg::*;

    // ------------------------
    // state
    // ------------------------
    typedef struct packed {
        logic [31:0] prdata;
        logic [CLK_CFG_W-1:0] clk_cfg;
        logic [NUM_CTRL-1:0] ctrl_en;
        logic [LOCAL_W-1:0] local_ctrl;
        logic [NUM_CELLS-1:0] op_a;
        logic [NUM_CELLS-1:0] op_b;
        cell_cfg_t [NUM_CELLS-1:0] cell_cfg;
        logic [NUM_ROW_CLK-1:0] row_s1;
        logic [NUM_ROW_CLK-1:0] row_s2;
        logic [1:0] rc_s1;
        logic [1:0] rc_s2;
        logic [NUM_CELLS-1:0] left_s1;
        logic [NUM_CELLS-1:0] left_s2;
        logic [NUM_CELLS-1:0] right_s1;
        logic [NUM_CELLS-1:0] right_s2;
        logic [1:0] chain_s1;
        logic [1:0] chain_s2;
        logic [7:0] lvl_prev;
        logic cout;
    } top_state_t;

    top_state_t s_q;
    top_state_t s_d;

    logic [7:0] lvl;
    logic [SEL_W-1:0] clk_sel [2];
    logic [1:0] clk_fall;
    logic [1:0] clk_used;
    logic [1:0] gate_ok;
    logic [1:0] clk_edge;
    logic dual;
    logic [SEL_W-1:0] aclr1_sel;
    cluster_ctrl_t ctrl;
    logic [NUM_ROUTE-1:0] route;
    logic [NUM_CELLS-1:0] q_all;
    logic [NUM_CELLS-1:0] lut_all;
    logic [NUM_CELLS-1:0] cout_all;
    logic [NUM_CTRL-1:0] in_use;
    logic [3:0] use_count;
    logic setup;
    logic wr_en;
    logic cell_hit;
    logic [ADDR_W-1:0] cell_off;
    logic [3:0] cell_idx;
    logic mapped;
    logic [31:0] rd_word;

    // ------------------------
    // cluster clock derivation
    // ------------------------

    // row lines plus the two local-routing clock sources
    assign lvl = {s_q.local_ctrl[LC_CLK2], s_q.local_ctrl[LC_CLK1], s_q.row_s2}; // RULE13

    // dual-edge mode ties clock two to clock one's line on the other edge
    always_comb
    begin
        dual = s_q.clk_cfg[DUAL_EDGE_BIT];
        clk_sel[0] = s_q.clk_cfg[CLK1_SEL_LSB +: SEL_W];
        clk_fall[0] = s_q.clk_cfg[CLK1_FALL_BIT];
        clk_sel[1] = dual ? clk_sel[0] : s_q.clk_cfg[CLK2_SEL_LSB +: SEL_W]; // RULE4
        clk_fall[1] = dual ? ~clk_fall[0] : s_q.clk_cfg[CLK2_FALL_BIT]; // RULE4
        clk_used[0] = s_q.ctrl_en[EN_CLK1] | dual;
        clk_used[1] = s_q.ctrl_en[EN_CLK2] | dual; // RULE4
        gate_ok[0] = ~s_q.ctrl_en[EN_GATE1] | s_q.local_ctrl[LC_GATE1];
        gate_ok[1] = ~s_q.ctrl_en[EN_GATE2] | s_q.local_ctrl[LC_GATE2];
    end

    // edge events of each cluster clock, each gated by its own gate
    generate
        for (genvar k = 0; k < 2; k++)
        begin : g_clk
            always_comb
            begin
                if (clk_fall[k])
                    clk_edge[k] = ~lvl[clk_sel[k]] & s_q.lvl_prev[clk_sel[k]];
                else
                    clk_edge[k] = lvl[clk_sel[k]] & ~s_q.lvl_prev[clk_sel[k]];
            end
            assign ctrl.clk_evt[k] = clk_used[k] & clk_edge[k] & gate_ok[k]; // RULE5
        end
    endgenerate

    // ------------------------
    // clears, loads and add/subtract
    // ------------------------

    // clear one may come from any row line, else from local routing
    assign aclr1_sel = s_q.clk_cfg[ACLR1_SEL_LSB +: SEL_W];

    always_comb
    begin
        if (aclr1_sel < SEL_W'(NUM_ROW_CLK))
            ctrl.aclr[0] = s_q.ctrl_en[EN_ACLR1] & s_q.row_s2[aclr1_sel]; // RULE13
        else
            ctrl.aclr[0] = s_q.ctrl_en[EN_ACLR1] & s_q.local_ctrl[LC_ACLR1];
        ctrl.aclr[1] = s_q.ctrl_en[EN_ACLR2] & s_q.local_ctrl[LC_ACLR2]; // RULE6
        ctrl.aload = s_q.ctrl_en[EN_ALOAD] & s_q.local_ctrl[LC_ALOAD]; // RULE6
        ctrl.sclr = s_q.ctrl_en[EN_SCLR] & s_q.local_ctrl[LC_SCLR];
        ctrl.sload = s_q.ctrl_en[EN_SLOAD] & s_q.local_ctrl[LC_SLOAD];
        ctrl.addsub = s_q.ctrl_en[EN_ADDSUB] & s_q.local_ctrl[LC_ADDSUB]; // RULE8
    end

    // controls in use; ten signals at most by construction
    always_comb
    begin
        in_use = s_q.ctrl_en;
        in_use[EN_CLK1] = clk_used[0];
        in_use[EN_CLK2] = clk_used[1];
        use_count = '0;
        for (int i = 0; i < NUM_CTRL; i++)
            use_count = use_count + 4'(in_use[i]); // RULE2
    end

    // ------------------------
    // local routing and the ten cells
    // ------------------------

    // own outputs, left and right direct links, row/column lines
    assign route = {s_q.rc_s2, s_q.right_s2, s_q.left_s2, q_all}; // RULE11 RULE12

    generate
        for (genvar i = 0; i < NUM_CELLS; i++)
        begin : g_cell // RULE1
            cell_in_t din;
            always_comb
            begin
                din.d1 = s_q.op_a[i];
                din.d2 = s_q.op_b[i];
                din.d3 = route[s_q.cell_cfg[i].d3_src];
                din.d4 = route[s_q.cell_cfg[i].d4_src];
                if (i == 0)
                begin
                    din.lut_chain = 1'b0;
                    din.reg_chain = s_q.chain_s2[1];
                    din.carry = ctrl.addsub | s_q.chain_s2[0]; // RULE14
                end
                else
                begin
                    din.lut_chain = lut_all[(i + NUM_CELLS - 1) % NUM_CELLS]; // RULE9
                    din.reg_chain = q_all[(i + NUM_CELLS - 1) % NUM_CELLS]; // RULE10
                    din.carry = cout_all[(i + NUM_CELLS - 1) % NUM_CELLS];
                end
            end

            logic_cell u_cell (
                .clk(clk),
                .rst_n(rst_n),
                .cfg(s_q.cell_cfg[i]),
                .ctrl(ctrl),
                .din(din),
                .lut_out(lut_all[i]),
                .carry_out(cout_all[i]),
                .q(q_all[i])
            );
        end
    endgenerate

    // ------------------------
    // apb decode and read mux
    // ------------------------

    // read data is captured in setup, so the access phase needs no wait
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite;
    assign cell_off = paddr - ADDR_CELL_BASE;
    assign cell_idx = cell_off[5:2];
    assign cell_hit = (paddr >= ADDR_CELL_BASE) && (paddr < ADDR_CELL_END)
        && (paddr[1:0] == 2'b00);

    always_comb
    begin
        mapped = 1'b1;
        rd_word = '0;
        if (cell_hit)
            rd_word = 32'(s_q.cell_cfg[cell_idx]);
        else
        begin
            unique case (paddr)
                ADDR_CLK_CFG: rd_word = 32'(s_q.clk_cfg);
                ADDR_CTRL_EN: rd_word = 32'(s_q.ctrl_en);
                ADDR_LOCAL: rd_word = 32'(s_q.local_ctrl);
                ADDR_OPERAND: rd_word = {6'h00, s_q.op_b, 6'h00, s_q.op_a};
                ADDR_STATUS:
                begin
                    rd_word[NUM_CELLS-1:0] = q_all;
                    rd_word[ST_LUT_LSB +: NUM_CELLS] = lut_all;
                    rd_word[ST_COUNT_LSB +: 4] = use_count;
                    rd_word[ST_COUT_BIT] = s_q.cout;
                    rd_word[ST_DUAL_BIT] = dual;
                end
                default: mapped = 1'b0;
            endcase
        end
    end

    // ------------------------
    // next state
    // ------------------------
    always_comb
    begin
        s_d = s_q;
        // two-stage synchronisers for every pin from the fabric
        s_d.row_s1 = row_clk;
        s_d.row_s2 = s_q.row_s1;
        s_d.rc_s1 = row_col_in;
        s_d.rc_s2 = s_q.rc_s1;
        s_d.left_s1 = link_left_in;
        s_d.left_s2 = s_q.left_s1;
        s_d.right_s1 = link_right_in;
        s_d.right_s2 = s_q.right_s1;
        s_d.chain_s1 = {reg_chain_in, carry_in};
        s_d.chain_s2 = s_q.chain_s1;
        s_d.lvl_prev = lvl;
        s_d.cout = cout_all[NUM_CELLS-1];
        if (setup)
            s_d.prdata = rd_word;
        if (wr_en && mapped)
        begin
            if (cell_hit)
                s_d.cell_cfg[cell_idx] = pwdata[CELL_CFG_W-1:0];
            else if (paddr == ADDR_CLK_CFG)
                s_d.clk_cfg = pwdata[CLK_CFG_W-1:0];
            else if (paddr == ADDR_CTRL_EN)
                s_d.ctrl_en = pwdata[NUM_CTRL-1:0];
            else if (paddr == ADDR_LOCAL)
                s_d.local_ctrl = pwdata[LOCAL_W-1:0];
            else if (paddr == ADDR_OPERAND)
            begin
                s_d.op_a = pwdata[NUM_CELLS-1:0];
                s_d.op_b = pwdata[OP_B_LSB +: NUM_CELLS];
            end
        end
    end

    // ------------------------
    // registers
    // ------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_q <= '0;
            s_q.clk_cfg <= CLK_CFG_RST;
            s_q.ctrl_en <= CTRL_EN_RST;
            s_q.local_ctrl <= LOCAL_RST;
            s_q.cell_cfg <= {NUM_CELLS{CELL_CFG_RST}};
        end
        else
            s_q <= s_d;
    end

    // ------------------------
    // outputs
    // ------------------------
    assign prdata = s_q.prdata;
    assign pready = 1'b1; // zero-wait slave
    assign pslverr = psel & penable & ~mapped;
    assign link_out = q_all; // RULE12
    assign carry_out = s_q.cout;
    assign reg_chain_out = q_all[NUM_CELLS-1]; // RULE10

endmodule : logic_cluster_control

// >>> sim/cluster_control_sva.sv
// port assertions for the logic cluster control block
// assumes it is bound onto logic_cluster_control
module cluster_control_sva
    import cluster_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // fabric pins
    input wire logic [5:0] row_clk,
    input wire logic [1:0] row_col_in,
    input wire logic [9:0] link_left_in,
    input wire logic [9:0] link_right_in,
    input wire logic carry_in,
    input wire logic reg_chain_in,
    input wire logic [9:0] link_out,
    input wire logic carry_out,
    input wire logic reg_chain_out
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic acc, map_ok;
    logic [3:0] quiet_q;
    assign acc = psel && penable;
    // the gap between status and the cells is a hole
    assign map_ok = (paddr[1:0] == 2'b00) && ((paddr <= ADDR_STATUS) ||
        (paddr >= ADDR_CELL_BASE && paddr < ADDR_CELL_END));
    // cycles since any pin moved or a register was written
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            quiet_q <= 4'h0;
        else if ($changed({row_clk, row_col_in, link_left_in, link_right_in, carry_in,
            reg_chain_in}) || (acc && pwrite))
            quiet_q <= 4'h0;
        else if (quiet_q != 4'hf)
            quiet_q <= quiet_q + 4'h1;
    end
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    chk_reset_quiet: assert property (disable iff (1'b0) !rst_n |->
        link_out == '0 && !carry_out && !reg_chain_out && pready)
        else $error("outputs not cleared in reset");
    chk_no_cause: assert property (quiet_q >= 4'd8 |-> $stable(link_out))
        else $error("cell register moved without a clock or control");
    chk_chain_tail: assert property (reg_chain_out == link_out[9])
        else $error("chain output differs from last cell");
    chk_status_q: assert property (acc && !pwrite && paddr == ADDR_STATUS |->
        prdata[9:0] == $past(link_out) && prdata[31:26] == '0)
        else $error("status does not show the ten registers");
    chk_ready_high: assert property (acc |-> pready)
        else $error("access phase without ready");
    chk_err_phase: assert property (pslverr |-> acc)
        else $error("error outside access phase");
    chk_err_hole: assert property (acc && !map_ok |-> pslverr ##1 !pslverr)
        else $error("hole access not refused");
    chk_err_mapped: assert property (acc && map_ok |-> !pslverr)
        else $error("mapped access refused");
    chk_hole_zero: assert property (acc && !pwrite && !map_ok |-> prdata == '0)
        else $error("hole read not zero");
endmodule : cluster_control_sva

bind logic_cluster_control cluster_control_sva u_sva (.clk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr, .row_clk, .row_col_in, .link_left_in,
    .link_right_in, .carry_in, .reg_chain_in, .link_out, .carry_out, .reg_chain_out);

// >>> sim/fabric_model.sv
// routing fabric and row clock lines around one cluster
// assumes clk is the cluster's own clock
module fabric_model (
    // clock
    input wire logic clk,
    // pins toward the cluster
    output logic [5:0] row_clk,
    output logic [1:0] row_col_in,
    output logic [9:0] link_left_in,
    output logic [9:0] link_right_in,
    output logic carry_in,
    output logic reg_chain_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    initial
    begin
        row_clk = 6'h00;
        row_col_in = 2'h0;
        link_left_in = 10'h2aa;
        link_right_in = 10'h155;
        carry_in = 1'b0;
        reg_chain_in = 1'b0;
    end
    // pulses stay up and down long enough for the synchroniser
    task automatic pulse(input int k);
        @(posedge clk);
        row_clk[k] <= 1'b1;
        repeat (4) @(posedge clk);
        row_clk[k] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : pulse
    // routing level and register chain level
    task automatic drive(input logic [1:0] rc, input logic ch);
        @(posedge clk);
        row_col_in <= rc;
        reg_chain_in <= ch;
    endtask : drive
    // direct links and carry into cell zero
    task automatic links(input logic [9:0] l, input logic [9:0] r, input logic c);
        @(posedge clk);
        link_left_in <= l;
        link_right_in <= r;
        carry_in <= c;
    endtask : links
endmodule : fabric_model

// >>> sim/logic_cluster_control_tb_top.sv
// self-checking bench for the logic cluster control block
// assumes fabric_model drives the routing pins
module logic_cluster_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cluster_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, er;
    logic pready, pslverr, carry_out, reg_chain_out, carry_in, reg_chain_in;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [5:0] row_clk;
    logic [1:0] row_col_in;
    logic [9:0] link_left_in, link_right_in, link_out;
    int fails, samples_checked;
    logic_cluster_control u_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .row_clk, .row_col_in, .link_left_in, .link_right_in,
        .carry_in, .reg_chain_in, .link_out, .carry_out, .reg_chain_out);
    fabric_model u_fab (.clk, .row_clk, .row_col_in, .link_left_in, .link_right_in,
        .carry_in, .reg_chain_in);
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic finish_test;
        $display("fails %0d samples_checked %0d", fails, samples_checked);
        if (fails == 0 && samples_checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            fails++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask : chk
    // one apb transfer; waits for ready under a bound
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 16)
        begin
            fails++;
            finish_test();
        end
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(n, e, rd);
    endtask : rdc
    task automatic lk(input string n, input logic [9:0] e);
        chk(n, {22'h0, e}, {22'h0, link_out});
    endtask : lk
    // status: carry and lookup outputs, then controls in use
    task automatic st(input logic [10:0] s, input logic [3:0] c);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("sum", {21'h0, s}, {21'h0, rd[24], rd[19:10]});
        chk("in_use", {28'h0, c}, {28'h0, rd[23:20]});
    endtask : st
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_regs;
        rdc("clk_cfg", ADDR_CLK_CFG, 32'h10);
        rdc("ctrl_en", ADDR_CTRL_EN, 32'h0);
        rdc("local", ADDR_LOCAL, 32'h0);
        apb(1'b1, 12'h014, 32'hffff_ffff);
        chk("wr_err", 32'h1, {31'h0, er});
        rdc("hole", 12'h014, 32'h0);
        apb(1'b0, 12'h006, 32'h0);
        chk("odd_err", 32'h1, {31'h0, er});
    endtask : s_regs
    task automatic s_shift;
        cell_cfg_t c;
        for (int i = 0; i < 10; i++)
        begin
            c = CELL_CFG_RST;
            c.reg_chain_en = 1'b1;
            c.arith = 1'b1;
            c.aclr_sel = (i >= 5);
            c.d3_src = 5'(10 + 10 * (i % 2) + i);
            wr(ADDR_CELL_BASE + 12'(4 * i), {1'b0, c});
        end
        wr(ADDR_CTRL_EN, 32'h1);
        u_fab.drive(2'h0, 1'b1);
        u_fab.pulse(0);
        u_fab.drive(2'h0, 1'b0);
        for (int i = 0; i < 10; i++)
        begin
            lk("shift", 10'(1 << i));
            if (i < 9)
                u_fab.pulse(0);
        end
        chk("tail", 32'h1, {31'h0, reg_chain_out});
    endtask : s_shift
    task automatic s_gate;
        u_fab.drive(2'h0, 1'b1);
        wr(ADDR_CTRL_EN, 32'h5);
        u_fab.pulse(0);
        lk("gated", 10'h200);
        wr(ADDR_LOCAL, 32'h1);
        u_fab.pulse(3);
        lk("other_row", 10'h200);
        u_fab.pulse(0);
        lk("open", 10'h001);
        wr(ADDR_CTRL_EN, 32'h9);
        wr(ADDR_LOCAL, 32'h0);
        u_fab.pulse(0);
        lk("pair", 10'h003);
    endtask : s_gate
    task automatic s_async;
        wr(ADDR_CLK_CFG, 32'he10);
        wr(ADDR_CTRL_EN, 32'hb1);
        u_fab.drive(2'h3, 1'b1);
        u_fab.links(10'h155, 10'h2aa, 1'b1);
        wr(ADDR_LOCAL, 32'h10);
        repeat (6) @(posedge clk);
        lk("preset", 10'h3ff);
        wr(ADDR_LOCAL, 32'h4);
        repeat (6) @(posedge clk);
        lk("clear_one", 10'h3e0);
        wr(ADDR_LOCAL, 32'hc);
        repeat (6) @(posedge clk);
        lk("clear_two", 10'h000);
        u_fab.pulse(0);
        lk("clear_wins", 10'h000);
    endtask : s_async
    task automatic s_sync;
        wr(ADDR_LOCAL, 32'h10);
        repeat (6) @(posedge clk);
        wr(ADDR_CTRL_EN, 32'h1c1);
        wr(ADDR_LOCAL, 32'h20);
        repeat (6) @(posedge clk);
        lk("sclr_wait", 10'h3ff);
        u_fab.pulse(0);
        lk("sclr", 10'h000);
        wr(ADDR_LOCAL, 32'h40);
        u_fab.pulse(0);
        lk("sload", 10'h3ff);
    endtask : s_sync
    task automatic s_arith;
        wr(ADDR_CTRL_EN, 32'h1);
        wr(ADDR_LOCAL, 32'h0);
        wr(ADDR_OPERAND, 32'h01e3_02f5);
        st(11'h4d9, 4'h1);
        u_fab.links(10'h155, 10'h2aa, 1'b0);
        wr(ADDR_CTRL_EN, 32'h201);
        wr(ADDR_LOCAL, 32'h80);
        st(11'h512, 4'h2);
        chk("carry_pin", 32'h1, {31'h0, carry_out});
        wr(ADDR_LOCAL, 32'h0);
        st(11'h4d8, 4'h2);
    endtask : s_arith
    task automatic s_dual;
        wr(ADDR_CLK_CFG, 32'h110);
        wr(ADDR_CTRL_EN, 32'h1);
        apb(1'b0, ADDR_STATUS, 32'h0);
        chk("dual", 32'h1, {31'h0, rd[25]});
        chk("dual_use", 32'h2, {28'h0, rd[23:20]});
    endtask : s_dual
    // ----------------------------------------
    // clock, reset and sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        fails = 0;
        samples_checked = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        s_regs();
        s_shift();
        s_gate();
        s_async();
        s_sync();
        s_arith();
        s_dual();
        finish_test();
    end
endmodule : logic_cluster_control_tb_top
